// File: include/dit_defines.svh
/*
  Register indices, field positions and reset values of the dual interval timer.
  Assumes a 32-bit APB slave in which register index n sits at byte address 4*n.
*/
`ifndef DIT_DEFINES_SVH
`define DIT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define DIT_IDX_PORT_B_OUTPUT 4'h0
`define DIT_IDX_PORT_B_DIRECTION 4'h2
`define DIT_IDX_FIRST_COUNT_LOW 4'h4
`define DIT_IDX_FIRST_COUNT_HIGH 4'h5
`define DIT_IDX_FIRST_LATCH_LOW 4'h6
`define DIT_IDX_FIRST_LATCH_HIGH 4'h7
`define DIT_IDX_SECOND_COUNT_LOW 4'h8
`define DIT_IDX_SECOND_COUNT_HIGH 4'h9
`define DIT_IDX_AUX_CONTROL 4'hB
`define DIT_IDX_INT_FLAGS 4'hD
`define DIT_IDX_INT_ENABLES 4'hE

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DIT_AUX_FST_FREE 6
`define DIT_AUX_FST_OUT 7
`define DIT_AUX_SND_PULSE 5
`define DIT_FLG_FST 6
`define DIT_FLG_SND 5
`define DIT_FLG_ANY 7
`define DIT_ENA_SET 7
`define DIT_PB_SEVEN 7
`define DIT_PB_SIX 6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DIT_RST_BYTE 8'h00
`define DIT_RST_COUNT 16'h0000
`define DIT_RST_PB_SEVEN 1'b1

`endif

// File: include/dit_pkg.sv
/*
  Types shared by the dual interval timer design.
  Assumes nothing beyond the defines header.
*/
package dit_pkg;

  // --------------------------------------------------------------------------
  // Bus slave phases, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DIT_IDLE = 2'b01,
    DIT_ACCESS = 2'b10
  } dit_apb_e;

endpackage

// File: hdl/dit_down_counter.sv
/*
  A 16-bit loadable down counter with zero detect.
  Assumes load has priority over decrement and that the count wraps below zero.
*/
`include "dit_defines.svh"
module dit_down_counter
  import dit_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic dec,
  output logic [15:0] count,
  output logic is_zero
);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count <= `DIT_RST_COUNT;
    end else if (load) begin
      count <= load_val;
    end else if (dec) begin
      count <= count - 16'h0001;
    end
  end

  assign is_zero = (count == 16'h0000);

endmodule

// File: hdl/dit_fall_detect.sv
/*
  Falling-edge detector for a pin level.
  Assumes the level is already synchronous to sys_clk.
*/
`include "dit_defines.svh"
module dit_fall_detect
  import dit_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic level,
  output logic fall
);

  logic prev_r;

  // Reset high, so a pin held low from reset is seen as a falling edge in the first cycle after reset.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= level;
    end
  end

  assign fall = prev_r & ~level;

endmodule

// File: hdl/dit_timer_top.sv
/*
  Dual interval timer with interrupt flagging, reached over APB.
  Assumes one 25 MHz clock that is also the count rate, and pins synchronous to it.
*/
//
// Functional notes
// - Auxiliary control bits 7:6 select four first timer modes.
// - Writing first latch low or first count low loads only the low latch.
// - Reading first latch low returns it and keeps the first flag.
// - First latch high is read/write, with no transfer into the counter.
// - First count low is filled only from the low latch, on high write or free-run reload.
// - First high write loads high latch, transfers low latch, counts next cycle.
// - One-shot first timer decrements every clock and flags once at zero.
// - With output bit set in one-shot, port B bit seven pulses low once.
// - First flag clears on high counter write or low counter read.
// - Free-run zero sets flag, toggles bit seven, reloads sixteen bits.
// - Free-run flags every time-out without software rewriting the timer.
// - High counter writes restart the full period; retriggering avoids time-out.
// - Latch-only writes leave current countdown; they set the next period.
// - Bit seven carries timer output only when direction and mode bits set.
// - One auxiliary bit selects second timer one-shot or pulse counting.
// - Second timer: write latch low, read count low, read/write count high.
// - Second one-shot wraps to FFFF, flags again only after high write.
// - Second count low read clears its flag; low write loads latch only.
// - Second high write loads high, transfers low latch, clears flag.
// - Pulse mode decrements per falling bit six edge, flags once per arm.
// - Interrupt line is driven low while any enabled flag is set.
// - All flags in one register; bit seven shows any enabled interrupt.
// - The first timer flag is bit six of the flag register.
// - Writing one to a flag bit clears it; flags are readable anytime.
`include "dit_defines.svh"
module dit_timer_top
  import dit_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic irq_n_out,
  output logic irq_n_oe
);

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  dit_apb_e state_r;
  logic [3:0] idx;
  logic mapped, setup, xfer, wr, rd;
  logic [7:0] wbyte, rd_byte;

  logic [7:0] orb_r, port_b_direction_r, aux_r, fst_lat_lo_r, fst_lat_hi_r, snd_lat_lo_r;
  logic fst_armed_r, snd_armed_r, fst_pb7_r, fst_flag_r, snd_flag_r;
  logic [1:0] ena_r, ena_nxt;
  logic fst_flag_nxt, snd_flag_nxt;
  logic [7:0] port_b_nxt, port_b_direction_nxt, aux_nxt;
  logic fst_pb7_nxt;

  logic [15:0] fst_cnt, snd_cnt, fst_load_val;
  logic fst_zero, snd_zero, fst_free, snd_pulse, fst_wr_hi, snd_wr_hi;
  logic fst_to, snd_to, fst_set, snd_set, fst_load, snd_dec, pb6_fall, irq_any;

  assign idx = paddr[5:2];
  assign setup = psel & ~penable;
  assign xfer = psel & penable & pready;
  assign wr = xfer & pwrite & pstrb[0] & mapped;
  assign rd = xfer & ~pwrite & mapped;
  assign wbyte = pwdata[7:0];

  assign mapped = (paddr[11:6] == 6'h00) && (idx inside {`DIT_IDX_PORT_B_OUTPUT, `DIT_IDX_PORT_B_DIRECTION,
    `DIT_IDX_FIRST_COUNT_LOW, `DIT_IDX_FIRST_COUNT_HIGH, `DIT_IDX_FIRST_LATCH_LOW, `DIT_IDX_FIRST_LATCH_HIGH,
    `DIT_IDX_SECOND_COUNT_LOW, `DIT_IDX_SECOND_COUNT_HIGH, `DIT_IDX_AUX_CONTROL, `DIT_IDX_INT_FLAGS,
    `DIT_IDX_INT_ENABLES});

  // Read data is sampled in the setup cycle, so every access takes one wait-free
  // access phase; the counters are therefore seen as they stood at setup.
  always_comb begin
    case (idx)
      `DIT_IDX_PORT_B_OUTPUT: rd_byte = (port_b_direction_r & orb_r) | (~port_b_direction_r & port_b_in);
      `DIT_IDX_PORT_B_DIRECTION: rd_byte = port_b_direction_r;
      `DIT_IDX_FIRST_COUNT_LOW: rd_byte = fst_cnt[7:0];
      `DIT_IDX_FIRST_COUNT_HIGH: rd_byte = fst_cnt[15:8];
      `DIT_IDX_FIRST_LATCH_LOW: rd_byte = fst_lat_lo_r;
      `DIT_IDX_FIRST_LATCH_HIGH: rd_byte = fst_lat_hi_r;
      `DIT_IDX_SECOND_COUNT_LOW: rd_byte = snd_cnt[7:0];
      `DIT_IDX_SECOND_COUNT_HIGH: rd_byte = snd_cnt[15:8];
      `DIT_IDX_AUX_CONTROL: rd_byte = aux_r;
      `DIT_IDX_INT_FLAGS: rd_byte = {irq_any, fst_flag_r, snd_flag_r, 5'h00};
      `DIT_IDX_INT_ENABLES: rd_byte = {1'b1, ena_r, 5'h00};
      default: rd_byte = `DIT_RST_BYTE;
    endcase
  end

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= DIT_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      case (state_r)
        DIT_IDLE: begin
          if (setup) begin
            state_r <= DIT_ACCESS;
            pready <= 1'b1;
            pslverr <= ~mapped;
            prdata <= (mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
          end
        end
        DIT_ACCESS: begin
          state_r <= DIT_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          state_r <= DIT_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Control registers and latches
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      orb_r <= `DIT_RST_BYTE;
      port_b_direction_r <= `DIT_RST_BYTE;
      aux_r <= `DIT_RST_BYTE;
    end else if (wr) begin
      if (idx == `DIT_IDX_PORT_B_OUTPUT) begin
        orb_r <= wbyte;
      end
      if (idx == `DIT_IDX_PORT_B_DIRECTION) begin
        port_b_direction_r <= wbyte;
      end
      if (idx == `DIT_IDX_AUX_CONTROL) begin
        aux_r <= wbyte;
      end
    end
  end

  // Latch writes never touch the running counters, so they only shape the next period.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fst_lat_lo_r <= `DIT_RST_BYTE;
      fst_lat_hi_r <= `DIT_RST_BYTE;
      snd_lat_lo_r <= `DIT_RST_BYTE;
    end else if (wr) begin
      if (idx == `DIT_IDX_FIRST_COUNT_LOW || idx == `DIT_IDX_FIRST_LATCH_LOW) begin
        fst_lat_lo_r <= wbyte;
      end
      if (idx == `DIT_IDX_FIRST_LATCH_HIGH || idx == `DIT_IDX_FIRST_COUNT_HIGH) begin
        fst_lat_hi_r <= wbyte;
      end
      if (idx == `DIT_IDX_SECOND_COUNT_LOW) begin
        snd_lat_lo_r <= wbyte;
      end
    end
  end

  // --------------------------------------------------------------------------
  // First timer
  // --------------------------------------------------------------------------
  assign fst_free = aux_r[`DIT_AUX_FST_FREE];
  assign fst_wr_hi = wr & (idx == `DIT_IDX_FIRST_COUNT_HIGH);
  // A time-out is the clock at which the count stands at zero and no high counter write comes; free-run reloads it there.
  assign fst_to = ~fst_wr_hi & fst_zero;
  assign fst_set = fst_to & (fst_free | fst_armed_r);
  assign fst_load = fst_wr_hi | (fst_to & fst_free);
  assign fst_load_val = fst_wr_hi ? {wbyte, fst_lat_lo_r} : {fst_lat_hi_r, fst_lat_lo_r};

  dit_down_counter u_fst_cnt (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .load(fst_load),
    .load_val(fst_load_val),
    .dec(1'b1),
    .count(fst_cnt),
    .is_zero(fst_zero)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fst_armed_r <= 1'b0;
      fst_pb7_r <= `DIT_RST_PB_SEVEN;
    end else if (fst_wr_hi) begin
      fst_armed_r <= 1'b1;
      fst_pb7_r <= 1'b0;
    end else if (fst_set) begin
      fst_armed_r <= 1'b0;
      fst_pb7_r <= fst_free ? ~fst_pb7_r : 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Second timer
  // --------------------------------------------------------------------------
  assign snd_pulse = aux_r[`DIT_AUX_SND_PULSE];
  assign snd_wr_hi = wr & (idx == `DIT_IDX_SECOND_COUNT_HIGH);
  assign snd_dec = snd_pulse ? pb6_fall : 1'b1;
  assign snd_to = ~snd_wr_hi & snd_dec & snd_zero;
  assign snd_set = snd_to & snd_armed_r;

  dit_fall_detect u_pb6_fall (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .level(port_b_in[`DIT_PB_SIX]),
    .fall(pb6_fall)
  );

  // The count wraps through zero to all ones and keeps running after a time-out.
  dit_down_counter u_snd_cnt (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .load(snd_wr_hi),
    .load_val({wbyte, snd_lat_lo_r}),
    .dec(snd_dec),
    .count(snd_cnt),
    .is_zero(snd_zero)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      snd_armed_r <= 1'b0;
    end else if (snd_wr_hi) begin
      snd_armed_r <= 1'b1;
    end else if (snd_set) begin
      snd_armed_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Flags, enables and interrupt line
  // --------------------------------------------------------------------------
  // A time-out in the cycle of a clear wins, so no event is lost.
  always_comb begin
    fst_flag_nxt = fst_flag_r;
    snd_flag_nxt = snd_flag_r;
    ena_nxt = ena_r;
    if (fst_wr_hi || (rd && idx == `DIT_IDX_FIRST_COUNT_LOW)) begin
      fst_flag_nxt = 1'b0;
    end
    if (snd_wr_hi || (rd && idx == `DIT_IDX_SECOND_COUNT_LOW)) begin
      snd_flag_nxt = 1'b0;
    end
    if (wr && idx == `DIT_IDX_INT_FLAGS) begin
      fst_flag_nxt = fst_flag_nxt & ~wbyte[`DIT_FLG_FST];
      snd_flag_nxt = snd_flag_nxt & ~wbyte[`DIT_FLG_SND];
    end
    if (wr && idx == `DIT_IDX_INT_ENABLES) begin
      if (wbyte[`DIT_ENA_SET]) begin
        ena_nxt = ena_r | wbyte[`DIT_FLG_FST:`DIT_FLG_SND];
      end else begin
        ena_nxt = ena_r & ~wbyte[`DIT_FLG_FST:`DIT_FLG_SND];
      end
    end
    if (fst_set) begin
      fst_flag_nxt = 1'b1;
    end
    if (snd_set) begin
      snd_flag_nxt = 1'b1;
    end
  end

  assign irq_any = (fst_flag_r & ena_r[1]) | (snd_flag_r & ena_r[0]);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fst_flag_r <= 1'b0;
      snd_flag_r <= 1'b0;
      ena_r <= 2'b00;
      irq_n_out <= 1'b0;
      irq_n_oe <= 1'b0;
    end else begin
      fst_flag_r <= fst_flag_nxt;
      snd_flag_r <= snd_flag_nxt;
      ena_r <= ena_nxt;
      irq_n_out <= 1'b0;
      irq_n_oe <= (fst_flag_nxt & ena_nxt[1]) | (snd_flag_nxt & ena_nxt[0]);
    end
  end

  // --------------------------------------------------------------------------
  // Port B pins
  // --------------------------------------------------------------------------
  // Built from next values so the pins move at the same edge as the registers.
  always_comb begin
    port_b_direction_nxt = (wr && idx == `DIT_IDX_PORT_B_DIRECTION) ? wbyte : port_b_direction_r;
    aux_nxt = (wr && idx == `DIT_IDX_AUX_CONTROL) ? wbyte : aux_r;
    fst_pb7_nxt = fst_pb7_r;
    if (fst_wr_hi) begin
      fst_pb7_nxt = 1'b0;
    end else if (fst_set) begin
      fst_pb7_nxt = fst_free ? ~fst_pb7_r : 1'b1;
    end
    port_b_nxt = (wr && idx == `DIT_IDX_PORT_B_OUTPUT) ? wbyte : orb_r;
    if (port_b_direction_nxt[`DIT_PB_SEVEN] && aux_nxt[`DIT_AUX_FST_OUT]) begin
      port_b_nxt[`DIT_PB_SEVEN] = fst_pb7_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port_b_out <= `DIT_RST_BYTE;
      port_b_oe <= `DIT_RST_BYTE;
    end else begin
      port_b_out <= port_b_nxt;
      port_b_oe <= port_b_direction_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  fst_load_a: assert property (fst_wr_hi |=> fst_cnt == {$past(wbyte), $past(fst_lat_lo_r)})
    else $error("first counter not loaded from high write and low latch");
  fst_latch_a: assert property (wr && idx == `DIT_IDX_FIRST_COUNT_LOW |=> fst_lat_lo_r == $past(wbyte))
    else $error("first low latch not loaded");
  latch_read_a: assert property (rd && idx == `DIT_IDX_FIRST_LATCH_LOW && !fst_set |=> fst_flag_r == $past(fst_flag_r))
    else $error("latch read changed first flag");
  fst_clear_a: assert property (rd && idx == `DIT_IDX_FIRST_COUNT_LOW && !fst_set |=> !fst_flag_r)
    else $error("first flag not cleared by low counter read");
  fst_oneshot_a: assert property (fst_to && !fst_free && fst_armed_r |=> fst_flag_r && !fst_armed_r && fst_pb7_r)
    else $error("one-shot time-out did not flag once");
  fst_free_a: assert property (fst_to && fst_free |=> fst_flag_r && fst_cnt == {$past(fst_lat_hi_r), $past(fst_lat_lo_r)})
    else $error("free-run time-out did not reload and flag");
  pin_seven_a: assert property (##1 port_b_out[`DIT_PB_SEVEN] == ((port_b_direction_r[7] && aux_r[7]) ? fst_pb7_r : orb_r[7]))
    else $error("port B bit seven has wrong source");
  snd_once_a: assert property (snd_to && !snd_armed_r && !snd_flag_r |=> !snd_flag_r)
    else $error("second flag set again without rearm");
  snd_pulse_a: assert property (snd_pulse && !pb6_fall && !snd_wr_hi |=> snd_cnt == $past(snd_cnt))
    else $error("pulse mode counted without a falling edge");
  irq_line_a: assert property (##1 irq_n_oe == irq_any)
    else $error("interrupt line disagrees with enabled flags");
  flag_write_a: assert property (wr && idx == `DIT_IDX_INT_FLAGS && wbyte[6] && !fst_set |=> !fst_flag_r)
    else $error("writing one did not clear first flag");

  free_run_c: cover property (fst_to && fst_free ##[1:100] fst_to && fst_free);
  pulse_out_c: cover property (snd_pulse && snd_set);
  irq_c: cover property (!irq_n_oe ##1 irq_n_oe);

endmodule

// File: verif/dit_host_model.sv
/*
  Host processor model: an APB master that runs one transfer at a time.
  Assumes a slave that answers with pready and a bench that calls xfer by hierarchy.
*/
module dit_host_model (
  input wire logic sys_clk,
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // --------------------------------------------------------------------------
  // One transfer
  // --------------------------------------------------------------------------
  // The wait has no bound of its own; the bench's cycle ceiling cuts a hang.
  task automatic xfer(input logic [3:0] idx, input logic wr, input logic [7:0] d, input logic [3:0] strb,
                      output logic [7:0] rd, output logic err);
    @(posedge sys_clk);
    paddr <= {6'h00, idx, 2'b00};
    pwrite <= wr;
    pwdata <= {24'h00_0000, d};
    pstrb <= strb;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle data is scrambled so a slave cannot lean on stale write data.
    pwdata <= ~pwdata;
  endtask
endmodule

// File: verif/dual_interval_timer_irq_bench.sv
/*
  Self-checking bench for the dual interval timer.
  Assumes the host model for bus traffic and drives port B pins itself.
*/
module dual_interval_timer_irq_bench
  import dit_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [3:0] idx;
    logic wr;
    logic [7:0] d;
    logic [3:0] strb;
    logic [7:0] exp;
    logic err;
  } dit_row_s;

  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, irq_n_out, irq_n_oe;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] port_b_in = 8'hFF;
  logic [7:0] port_b_out, port_b_oe;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  dit_row_s rows [17] = '{
    '{4'h6, 1'b1, 8'h5A, 4'hF, 8'h00, 1'b0}, '{4'h6, 1'b0, 8'h00, 4'hF, 8'h5A, 1'b0},
    '{4'h4, 1'b1, 8'h3C, 4'hF, 8'h00, 1'b0}, '{4'h6, 1'b0, 8'h00, 4'hF, 8'h3C, 1'b0},
    '{4'h7, 1'b1, 8'hA5, 4'hF, 8'h00, 1'b0}, '{4'h7, 1'b0, 8'h00, 4'hF, 8'hA5, 1'b0},
    '{4'h6, 1'b1, 8'h11, 4'h2, 8'h00, 1'b0}, '{4'h6, 1'b0, 8'h00, 4'hF, 8'h3C, 1'b0},
    '{4'hE, 1'b1, 8'hE0, 4'hF, 8'h00, 1'b0}, '{4'hE, 1'b0, 8'h00, 4'hF, 8'hE0, 1'b0},
    '{4'hE, 1'b1, 8'h60, 4'hF, 8'h00, 1'b0}, '{4'hE, 1'b0, 8'h00, 4'hF, 8'h80, 1'b0},
    '{4'h1, 1'b0, 8'h00, 4'hF, 8'h00, 1'b1}, '{4'hB, 1'b0, 8'h00, 4'hF, 8'h00, 1'b0},
    '{4'h0, 1'b1, 8'h5A, 4'hF, 8'h00, 1'b0}, '{4'h2, 1'b1, 8'h0F, 4'hF, 8'h00, 1'b0},
    '{4'h0, 1'b0, 8'h00, 4'hF, 8'hFA, 1'b0}
  };

  always #20 sys_clk = ~sys_clk;

  dit_host_model host (.sys_clk(sys_clk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  dit_timer_top dut (.sys_clk(sys_clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe(port_b_oe), .irq_n_out(irq_n_out),
    .irq_n_oe(irq_n_oe));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] v;
    logic e;
    host.xfer(idx, 1'b1, d, 4'hF, v, e);
  endtask

  task automatic rd(input logic [3:0] idx, output logic [7:0] v);
    logic e;
    host.xfer(idx, 1'b0, 8'h00, 4'hF, v, e);
  endtask

  // Polls the flag register until every bit of the mask is set.
  task automatic poll(input logic [7:0] m, output logic [7:0] v);
    int k;
    k = 0;
    v = 8'h00;
    while ((v & m) !== m && k < 300) begin
      rd(4'hD, v);
      k++;
    end
  endtask

  task automatic pulse();
    @(posedge sys_clk);
    port_b_in[6] <= 1'b0;
    repeat (3) @(posedge sys_clk);
    port_b_in[6] <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic e;
    repeat (10) @(negedge sys_clk);
    chk(port_b_oe | port_b_out | {7'h00, irq_n_oe}, 8'h00);
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      host.xfer(rows[i].idx, rows[i].wr, rows[i].d, rows[i].strb, v, e);
      chk({7'h00, e}, {7'h00, rows[i].err});
      if (!rows[i].wr) chk(v, rows[i].exp);
    end
    @(negedge sys_clk);
    chk(port_b_out, 8'h5A);
    chk(port_b_oe, 8'h0F);
    // One-shot first timer with pin output and interrupt enabled.
    wr(4'h2, 8'h80);
    wr(4'hB, 8'h80);
    wr(4'hE, 8'hC0);
    wr(4'h4, 8'h20);
    wr(4'h5, 8'h00);
    @(negedge sys_clk);
    chk({7'h00, port_b_out[7]}, 8'h00);
    rd(4'h4, v);
    chk(v, 8'h1F);
    poll(8'h40, v);
    chk(v, 8'hC0);
    @(negedge sys_clk);
    chk({6'h00, port_b_out[7], irq_n_oe}, 8'h03);
    chk({7'h00, irq_n_out}, 8'h00);
    rd(4'h6, v);
    chk(v, 8'h20);
    rd(4'hD, v);
    chk(v, 8'hC0);
    rd(4'h4, v);
    rd(4'hD, v);
    chk(v, 8'h00);
    // Retrigger before time-out, then let it run out.
    wr(4'hB, 8'h00);
    wr(4'h6, 8'h30);
    wr(4'h5, 8'h00);
    repeat (4) begin
      repeat (20) @(posedge sys_clk);
      wr(4'h5, 8'h00);
    end
    rd(4'hD, v);
    chk(v, 8'h00);
    poll(8'h40, v);
    chk(v, 8'hC0);
    wr(4'h5, 8'h00);
    rd(4'hD, v);
    chk(v, 8'h00);
    // Free-run with the pin toggling.
    wr(4'hB, 8'hC0);
    wr(4'h6, 8'h10);
    wr(4'h5, 8'h00);
    poll(8'h40, v);
    chk(v, 8'hC0);
    @(negedge sys_clk);
    chk({7'h00, port_b_out[7]}, 8'h01);
    wr(4'hD, 8'h40);
    rd(4'hD, v);
    chk(v, 8'h00);
    poll(8'h40, v);
    chk(v, 8'hC0);
    wr(4'h2, 8'h00);
    repeat (2) begin
      @(negedge sys_clk);
      chk({port_b_out[7], port_b_oe[7]}, 8'h00);
      repeat (40) @(posedge sys_clk);
    end
    wr(4'hB, 8'h00);
    wr(4'hE, 8'h40);
    wr(4'hD, 8'h60);
    // Second timer one-shot.
    wr(4'hE, 8'hA0);
    wr(4'h8, 8'h08);
    wr(4'h9, 8'h00);
    poll(8'h20, v);
    chk(v & 8'hA0, 8'hA0);
    rd(4'h9, v);
    chk(v, 8'hFF);
    rd(4'h8, v);
    rd(4'hD, v);
    chk(v & 8'h20, 8'h00);
    repeat (40) @(posedge sys_clk);
    rd(4'hD, v);
    chk(v & 8'h20, 8'h00);
    // Second timer counting pin pulses.
    wr(4'hB, 8'h20);
    wr(4'h8, 8'h03);
    wr(4'h9, 8'h00);
    repeat (30) @(posedge sys_clk);
    rd(4'h8, v);
    chk(v, 8'h03);
    repeat (3) pulse();
    rd(4'h8, v);
    chk(v, 8'h00);
    pulse();
    rd(4'hD, v);
    chk(v & 8'hA0, 8'hA0);
    @(negedge sys_clk);
    chk({7'h00, irq_n_oe}, 8'h01);
    // A reset in mid-run clears pins, enables and flags.
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(negedge sys_clk);
    chk(port_b_out | port_b_oe | {7'h00, irq_n_oe}, 8'h00);
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(4'hE, v);
    chk(v, 8'h80);
    rd(4'hD, v);
    chk(v, 8'h00);
    stop_test();
  end
endmodule
